/* hw/exec_group_map.vh */
`ifndef EXEC_GROUP_MAP_VH
`define EXEC_GROUP_MAP_VH
// Opcode fields
`define MAJOR_GROUP_A 6'h00
`define MAJOR_CACHE_OP 6'h08
`define MAJOR_BRANCH_ON_ADD_OVERFLOW_OP 6'h1D
`define MAJOR_BRANCH_ON_NO_ADD_OVERFLOW_OP 6'h1F
`define MAJOR_UNCOND_BR 6'h25
`define BITREV_ZERO_FIELD 4'h0
`define BITREV_MINOR 6'h2C
`define EXT_GROUP_MINOR 6'h3C
`define BREAK_MINOR 6'h07
`define CACHE_SUBOP 4'h6
// Cache select codes
`define CSEL_PRI_INSN 2'h0
`define CSEL_PRI_DATA 2'h1
`define CSEL_TERTIARY 2'h2
`define CSEL_SECONDARY 2'h3
// Reset vector and sequential PC step
`define PC_RESET 32'hBFC00000
`define SEQ_STEP 32'h00000004
`endif

/* hw/r6_branch_byte_bit_reverse_cache_exec.v */
`timescale 1ns/100ps
//
// Behaviour
// RULE1: Unconditional branch target is pc+4 plus offset*2
// RULE2: Break always raises breakpoint exception immediately; here a break arriving in the cache wait cycle is dropped
// RULE3: Decode bit reverse from group a fields
// RULE4: Reverse bits inside each byte lane
// RULE5: Overflow branch taken when signed add overflows
// RULE6: No-overflow branch taken when add does not
// RULE7: Overflow is sum bit 32 differs bit 31
// RULE8: Offset shifted one, added to pc+4
// RULE9: Taken branch squashes the following instruction
// RULE10: Register zero operands allowed, normal result
// RULE11: Back-to-back branches execute correctly
// RULE12: Cache address is base plus signed 9-bit offset
// RULE13: Physical cache uses translated address
// RULE14: Virtual cache uses effective address, may translate
// RULE15: Index operations still request translation
// RULE16: Software should use unmapped index addresses
// RULE17: Boundaries from bytes per tag, size, ways
// RULE18: Way and index sliced from address bits
// RULE19: Decode two-bit cache select field
// RULE20: No alignment error on cache addresses
`include "exec_group_map.vh"

module r6_branch_byte_bit_reverse_cache_exec #(
  parameter BYTES_PER_TAG_LOG2 = 4,
  parameter CACHE_SIZE_LOG2 = 14,
  parameter WAYS_LOG2 = 2,
  parameter CACHE_IS_PHYSICAL = 1,
  parameter INDEX_USES_PHYSICAL = 1
) (
  input wire clk_sys,
  input wire resetn,
  input wire insn_valid,
  input wire [31:0] insn_word,
  input wire [31:0] insn_pc,
  input wire [31:0] rs_value,
  input wire [31:0] rt_value,
  input wire [31:0] xlat_paddr,
  input wire xlat_fault,
  output reg redirect_valid,
  output reg [31:0] redirect_pc,
  output reg squash_next,
  output reg break_exception,
  output reg [31:0] exception_pc,
  output reg wb_valid,
  output reg [4:0] wb_reg,
  output reg [31:0] wb_data,
  output reg xlat_req,
  output reg [31:0] xlat_vaddr,
  output reg cache_req,
  output reg [1:0] cache_select,
  output reg [2:0] cache_operation,
  output reg cache_by_index,
  output reg [31:0] cache_addr,
  output reg [WAYS_LOG2:0] cache_way,
  output reg [CACHE_SIZE_LOG2-1:0] cache_index,
  output reg tlb_exception
);

localparam INDEX_BIT = CACHE_SIZE_LOG2 - WAYS_LOG2;
localparam WAY_BIT = INDEX_BIT + WAYS_LOG2;
localparam IDX_W = INDEX_BIT - BYTES_PER_TAG_LOG2;
localparam CS_IDLE = 1'b0;
localparam CS_WAIT = 1'b1;

// Cache sequencer state, declared early since the issue gate reads it
reg cstate_q;
reg [31:0] ea_q;
reg [4:0] op_q;
reg idx_q;

////////////////////////////////////////////////////////////////
reg rst_s1_q;
reg rst_s2_q;
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    rst_s1_q <= 1'b0;
    rst_s2_q <= 1'b0;
  end else begin
    rst_s1_q <= 1'b1;
    rst_s2_q <= rst_s1_q;
  end
end
wire rst_n = rst_s2_q;

////////////////////////////////////////////////////////////////
// Decode
wire [5:0] major = insn_word[31:26];
wire [4:0] f_rt = insn_word[25:21];
wire [4:0] f_rd = insn_word[20:16];
wire [31:0] next_pc = insn_pc + `SEQ_STEP;
wire is_group_a = (major == `MAJOR_GROUP_A) && (insn_word[5:0] == `EXT_GROUP_MINOR);
wire is_bitrev = is_group_a && (insn_word[15:12] == `BITREV_ZERO_FIELD) &&
  (insn_word[11:6] == `BITREV_MINOR); // RULE3
wire is_break = (major == `MAJOR_GROUP_A) && (insn_word[5:0] == `BREAK_MINOR);
wire is_uncond = (major == `MAJOR_UNCOND_BR);
wire is_branch_on_add_overflow = (major == `MAJOR_BRANCH_ON_ADD_OVERFLOW_OP);
wire is_branch_on_no_add_overflow = (major == `MAJOR_BRANCH_ON_NO_ADD_OVERFLOW_OP);
wire is_cache = (major == `MAJOR_CACHE_OP) && (insn_word[15:12] == `CACHE_SUBOP);

////////////////////////////////////////////////////////////////
// Bit reverse per byte lane; lanes never mix
wire [31:0] swapped;
genvar lane;
generate
  for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
    byte_lane_reverse #(
      .W(8)
    ) u_rev (
      .lane_in(rt_value[lane*8+7:lane*8]),
      .lane_out(swapped[lane*8+7:lane*8])
    ); // RULE4
  end
endgenerate

// Overflow detect, 33-bit sum; zero operands give no overflow
wire [32:0] wide_sum = {rs_value[31], rs_value} + {rt_value[31], rt_value}; // RULE7 RULE10
wire sum_ovf = wide_sum[32] ^ wide_sum[31]; // RULE7
wire ovf_taken = (is_branch_on_add_overflow && sum_ovf) || (is_branch_on_no_add_overflow && !sum_ovf); // RULE5 RULE6
wire [31:0] ovf_target = next_pc + {{15{insn_word[15]}}, insn_word[15:0], 1'b0}; // RULE8
wire [31:0] uncond_target = next_pc + {{5{insn_word[25]}}, insn_word[25:0], 1'b0}; // RULE1

// Cache effective address; misalignment never faults
wire [31:0] eff_addr = rs_value + {{23{insn_word[8]}}, insn_word[8:0]}; // RULE12 RULE20
wire cache_index_op = (insn_word[25:23] == 3'h0) || (insn_word[25:23] == 3'h1) ||
  (insn_word[25:23] == 3'h2);

// Address used for way and index, chosen by the latched operation kind
wire [31:0] sel_addr = idx_q ? (INDEX_USES_PHYSICAL ? xlat_paddr : ea_q) :
  (CACHE_IS_PHYSICAL ? xlat_paddr : ea_q);

////////////////////////////////////////////////////////////////
// Issue gate; an instruction in the cache wait cycle is dropped
wire issue = insn_valid && (cstate_q == CS_IDLE); // RULE11
wire take_break = issue && is_break;
wire take_uncond = issue && !is_break && is_uncond;
wire take_ovf = issue && !is_break && !is_uncond && ovf_taken;
wire take_bitrev = issue && !is_break && !is_uncond && !ovf_taken && is_bitrev;

////////////////////////////////////////////////////////////////
// Redirect; each branch stands alone so back-to-back branches work
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    redirect_valid <= 1'b0;
    redirect_pc <= `PC_RESET;
    squash_next <= 1'b0;
  end else begin
    redirect_valid <= 1'b0;
    squash_next <= 1'b0;
    if (take_uncond) begin
      redirect_valid <= 1'b1; // RULE1
      redirect_pc <= uncond_target; // RULE1
      squash_next <= 1'b1; // RULE9
    end else if (take_ovf) begin
      redirect_valid <= 1'b1; // RULE5 RULE6
      redirect_pc <= ovf_target; // RULE8
      squash_next <= 1'b1; // RULE9
    end
  end
end

////////////////////////////////////////////////////////////////
// Breakpoint trap; the code field is left for the handler to fetch
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    break_exception <= 1'b0;
    exception_pc <= `PC_RESET;
  end else begin
    break_exception <= 1'b0;
    if (take_break) begin
      break_exception <= 1'b1; // RULE2
      exception_pc <= insn_pc;
    end
  end
end

////////////////////////////////////////////////////////////////
// Register writeback of the reversed word
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    wb_valid <= 1'b0;
    wb_reg <= 5'h00;
    wb_data <= 32'h00000000;
  end else begin
    wb_valid <= 1'b0;
    if (take_bitrev) begin
      wb_valid <= 1'b1; // RULE3
      wb_reg <= f_rd; // RULE3
      wb_data <= swapped; // RULE4
    end
  end
end

////////////////////////////////////////////////////////////////
// Cache operation: translate first, then address the cache
always @(posedge clk_sys or negedge rst_n) begin
  if (!rst_n) begin
    cstate_q <= CS_IDLE;
    ea_q <= 32'h00000000;
    op_q <= 5'h00;
    idx_q <= 1'b0;
    xlat_req <= 1'b0;
    xlat_vaddr <= 32'h00000000;
    cache_req <= 1'b0;
    cache_select <= `CSEL_PRI_INSN;
    cache_operation <= 3'h0;
    cache_by_index <= 1'b0;
    cache_addr <= 32'h00000000;
    cache_way <= {(WAYS_LOG2+1){1'b0}};
    cache_index <= {CACHE_SIZE_LOG2{1'b0}};
    tlb_exception <= 1'b0;
  end else begin
    xlat_req <= 1'b0;
    cache_req <= 1'b0;
    tlb_exception <= 1'b0;
    case (cstate_q)
      CS_IDLE: begin
        if (insn_valid && is_cache) begin
          ea_q <= eff_addr; // RULE12
          op_q <= f_rt;
          idx_q <= cache_index_op; // RULE15
          xlat_req <= 1'b1; // RULE13 RULE14 RULE15
          xlat_vaddr <= eff_addr;
          cstate_q <= CS_WAIT;
        end
      end
      CS_WAIT: begin
        cstate_q <= CS_IDLE;
        if (xlat_fault) begin
          tlb_exception <= 1'b1; // RULE14
        end else begin
          cache_req <= 1'b1;
          cache_select <= op_q[1:0]; // RULE19
          cache_operation <= op_q[4:2];
          cache_by_index <= idx_q;
          // Index source is a build choice; unmapped addresses make both agree
          if (idx_q) begin
            cache_addr <= INDEX_USES_PHYSICAL ? xlat_paddr : ea_q; // RULE15
          end else begin
            cache_addr <= CACHE_IS_PHYSICAL ? xlat_paddr : ea_q; // RULE13 RULE14
          end
          cache_way <= (WAYS_LOG2 == 0) ? {(WAYS_LOG2+1){1'b0}} :
            {1'b0, sel_addr[WAY_BIT-1:INDEX_BIT]}; // RULE17 RULE18
          cache_index <= {{(CACHE_SIZE_LOG2-IDX_W){1'b0}}, sel_addr[INDEX_BIT-1:BYTES_PER_TAG_LOG2]}; // RULE18
        end
      end
      default: cstate_q <= CS_IDLE;
    endcase
  end
end

endmodule

////////////////////////////////////////////////////////////////
// One byte lane, bits mirrored end for end
module byte_lane_reverse #(
  parameter W = 8
) (
  input wire [W-1:0] lane_in,
  output wire [W-1:0] lane_out
);

genvar k;
generate
  for (k = 0; k < W; k = k + 1) begin : g_bit
    assign lane_out[k] = lane_in[W-1-k]; // RULE4
  end
endgenerate

endmodule

/* sim/exec_props.sv */
`timescale 1ns/100ps
module exec_props (
  input wire clk_sys, input wire resetn, input wire insn_valid, input wire [31:0] insn_word,
  input wire [31:0] insn_pc, input wire [31:0] rs_value, input wire [31:0] rt_value,
  input wire redirect_valid, input wire [31:0] redirect_pc, input wire squash_next,
  input wire break_exception, input wire [31:0] exception_pc, input wire wb_valid,
  input wire [4:0] wb_reg, input wire [31:0] wb_data, input wire xlat_req,
  input wire [31:0] xlat_vaddr, input wire cache_req, input wire tlb_exception
);
  ////////////////////////////////////////
  wire [5:0] maj = insn_word[31:26];
  wire [32:0] sum = {rs_value[31], rs_value} + {rt_value[31], rt_value};
  wire ovf = sum[32] ^ sum[31];
  wire [31:0] t16 = insn_pc + 32'h4 + {{15{insn_word[15]}}, insn_word[15:0], 1'b0};
  wire [31:0] t26 = insn_pc + 32'h4 + {{5{insn_word[25]}}, insn_word[25:0], 1'b0};
  wire bov = insn_valid && maj == 6'h1D;
  wire bnv = insn_valid && maj == 6'h1F;
  wire brk = insn_valid && maj == 6'h00 && insn_word[5:0] == 6'h07;
  wire bsw = insn_valid && maj == 6'h00 && insn_word[15:0] == 16'h0B3C;
  wire cop = insn_valid && maj == 6'h08 && insn_word[15:9] == 7'h30;
  wire [31:0] ea = rs_value + {{23{insn_word[8]}}, insn_word[8:0]};
  wire [31:0] swp;
  genvar i;
  for (i = 0; i < 32; i = i + 1) begin : g_swap
    assign swp[i] = rt_value[(i & 24) + 7 - (i & 7)];
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ovf_taken: assert property (bov && ovf |=> redirect_valid && redirect_pc == $past(t16))
    else $error("ovf branch");
  a_novf_taken: assert property (bnv && !ovf |=> redirect_valid && redirect_pc == $past(t16))
    else $error("novf branch");
  a_branch_held: assert property ((bov && !ovf) || (bnv && ovf) |=> !redirect_valid)
    else $error("false branch");
  a_squash_taken: assert property (redirect_valid |-> squash_next)
    else $error("no squash");
  a_uncond_target: assert property (insn_valid && maj == 6'h25 |=> redirect_valid && redirect_pc == $past(t26))
    else $error("uncond target");
  a_break_now: assert property (brk |=> break_exception && exception_pc == $past(insn_pc))
    else $error("break");
  a_byte_bit_reverse_write: assert property (bsw |=> wb_valid && wb_data == $past(swp) &&
    wb_reg == $past(insn_word[20:16]))
    else $error("byte_bit_reverse");
  a_cache_addr: assert property (cop |=> xlat_req && xlat_vaddr == $past(ea))
    else $error("cache ea");
  a_cache_finish: assert property (xlat_req |-> ##[1:2] (cache_req || tlb_exception))
    else $error("cache stall");
  c_ovf: cover property (bov && ovf);
  c_cache: cover property (cache_req);
  c_fault: cover property (tlb_exception);
endmodule
bind r6_branch_byte_bit_reverse_cache_exec exec_props u_props (.*);

/* sim/xlat_model.sv */
`timescale 1ns/100ps
module xlat_model (
  input wire clk_sys, input wire xlat_req, input wire [31:0] xlat_vaddr, input wire fault_en,
  output wire [31:0] xlat_paddr, output wire xlat_fault
);
  reg [31:0] last_q = 32'h0;
  reg live_q = 1'b0;
  // Answer stands through the sample cycle and one cycle after it, then inverts so stale use shows
  assign xlat_paddr = xlat_req ? {4'h2, xlat_vaddr[27:0]} : (live_q ? last_q : ~last_q);
  assign xlat_fault = fault_en && (xlat_req || live_q);
  always @(posedge clk_sys) begin
    live_q <= xlat_req;
    if (xlat_req) last_q <= {4'h2, xlat_vaddr[27:0]};
  end
endmodule

/* sim/r6_branch_byte_bit_reverse_cache_exec_bench.sv */
`timescale 1ns/100ps
module r6_branch_byte_bit_reverse_cache_exec_bench;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg insn_valid = 1'b0;
  reg fault_en = 1'b0;
  reg [31:0] insn_word = 32'h0, insn_pc = 32'h0, rs_value = 32'h0, rt_value = 32'h0, a, b, e;
  wire [31:0] xlat_paddr, redirect_pc, exception_pc, wb_data, xlat_vaddr, cache_addr;
  wire xlat_fault, redirect_valid, squash_next, break_exception, wb_valid, xlat_req, cache_req;
  wire cache_by_index, tlb_exception;
  wire [4:0] wb_reg;
  wire [1:0] cache_select;
  wire [2:0] cache_operation, cache_way;
  wire [13:0] cache_index;
  integer bad_count = 0, checked = 0, i, n;
  always #2 clk_sys = ~clk_sys;
  r6_branch_byte_bit_reverse_cache_exec dut (.*);
  xlat_model far_end (.clk_sys, .xlat_req, .xlat_vaddr, .fault_en, .xlat_paddr, .xlat_fault);
  ////////////////////////////////////////
  function [31:0] swapb(input [31:0] x);
    integer k;
    for (k = 0; k < 32; k = k + 1) swapb[k] = x[(k & 24) + 7 - (k & 7)];
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One instruction, then look at the cycle that carries its answer
  task run(input [31:0] w, input [31:0] s, input [31:0] t);
    @(posedge clk_sys);
    #1;
    insn_word = w;
    rs_value = s;
    rt_value = t;
    insn_pc = $urandom & 32'hFFFFFFFC;
    insn_valid = 1'b1;
    @(posedge clk_sys);
    #1 insn_valid = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    n = $urandom(76229);
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    for (i = 0; i < 16; i = i + 1) begin
      a = (i < 2) ? {32{i[0]}} : $urandom;
      run({16'h0, 16'h0B3C} | (i << 16), a, a);
      chk({wb_valid, wb_reg}, {1'b1, i[4:0]});
      chk(wb_data, swapb(a));
    end
    // Zero operands first, then both edges of the signed range
    for (i = 0; i < 24; i = i + 1) begin
      a = (i < 4) ? 32'h0 : (i < 8) ? 32'h7FFFFFFF : (i < 12) ? 32'h80000000 : $urandom;
      b = (i < 4) ? 32'h0 : (i < 8) ? {31'h0, i[0]} : (i < 12) ? {32{i[0]}} : $urandom;
      e = $urandom;
      run({i[1] ? 6'h1F : 6'h1D, e[25:0]}, a, b);
      n = ((a[31] == b[31]) && (a[31] != (a + b) >> 31)) ^ i[1];
      chk({redirect_valid, squash_next}, {n[0], n[0]});
      if (n[0]) chk(redirect_pc, insn_pc + 4 + {{15{e[15]}}, e[15:0], 1'b0});
    end
    for (i = 0; i < 6; i = i + 1) begin
      e = $urandom;
      run({6'h25, e[25:0]}, 32'h0, 32'h0);
      chk(redirect_valid, 1'b1);
      chk(squash_next, 1'b1);
      chk(redirect_pc, insn_pc + 4 + {{5{e[25]}}, e[25:0], 1'b0});
      run({6'h00, e[25:6], 6'h07}, 32'h0, 32'h0);
      chk(break_exception, 1'b1);
      chk(exception_pc, insn_pc);
    end
    // Bases kept in the unmapped upper segment
    for (i = 0; i < 8; i = i + 1) begin
      a = {3'h4, 29'h0} | ($urandom >> 3);
      e = $urandom;
      fault_en = (i == 7);
      run({6'h08, i[2:0], i[1:0], 5'h0, 7'h30, e[8:0]}, a, a);
      b = a + {{23{e[8]}}, e[8:0]};
      chk(xlat_req, 1'b1);
      chk(xlat_vaddr, b);
      b = {4'h2, b[27:0]};
      n = 0;
      while (!(cache_req || tlb_exception) && n < 4) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      chk({cache_req, tlb_exception}, {i != 7, i == 7});
      if (i != 7) chk({cache_select, cache_operation, cache_by_index}, {i[1:0], i[2:0], i < 3});
      if (i != 7) chk(cache_addr, b);
      if (i != 7) chk({cache_way, cache_index}, {1'b0, b[13:12], 6'h0, b[11:4]});
      @(posedge clk_sys);
      #1;
    end
    results;
  end
endmodule
